// file: rtl/sepp_pkg.sv
// Shared constants and types for the secure element packet port.
// Assumes a 100 MHz reference clock and a fast link sampling clock.
package sepp_pkg;

	localparam int REF_CLK_MHZ = 100;

	// Buffer geometry
	localparam int BUF_AW = 7;
	localparam int BUF_DEPTH = 128;
	localparam logic [7:0] BUF_DEPTH_B = 8'h80;

	// Word address function codes
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam logic [7:0] FUNC_SLEEP = 8'h01;
	localparam logic [7:0] FUNC_IDLE = 8'h02;
	localparam logic [7:0] FUNC_CMD = 8'h03;
	// Reserved code parked in the selector between packets
	localparam logic [7:0] FUNC_NONE = 8'hFF;

	// Output group returned when no command results are valid
	localparam logic [7:0] GROUP_COUNT = 8'h04;
	// Status and check bytes of the default group; values are arbitrary
	localparam logic [7:0] GROUP_STATUS = 8'h00;
	localparam logic [7:0] GROUP_CRC_LO = 8'h00;
	localparam logic [7:0] GROUP_CRC_HI = 8'h00;

	// Values after reset
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] RESET_PTR = 7'h00;

	// Timing
	localparam int WAKE_LOW_US = 60;
	localparam int WAKE_LOW_CYCLES = WAKE_LOW_US * REF_CLK_MHZ;
	localparam int WATCHDOG_MS = 1300;
	localparam int WATCHDOG_CYCLES = WATCHDOG_MS * REF_CLK_MHZ * 1000;
	localparam int WATCHDOG_BIT = 2;
	localparam int WD_W = 28;
	localparam int WL_W = 16;

	// Position of the last bit of a byte in the bit counter
	localparam logic [3:0] LAST_BIT = 4'h7;

	typedef enum logic [1:0] {
		SEPP_EV_WADDR,
		SEPP_EV_WDATA,
		SEPP_EV_STOP,
		SEPP_EV_RD
	} sepp_ev_e;

	typedef enum logic [1:0] {
		SEPP_M_AWAKE,
		SEPP_M_IDLE,
		SEPP_M_SLEEP
	} sepp_mode_e;

	typedef enum logic [2:0] {
		SEPP_L_IDLE,
		SEPP_L_ADDR,
		SEPP_L_WR,
		SEPP_L_ACK,
		SEPP_L_RD,
		SEPP_L_MACK
	} sepp_lstate_e;

endpackage

// file: rtl/sepp_buf_mem.sv
// Byte-wide buffer with one write port and a registered read port.
// Assumes both ports share one clock; reset clears every cell.
`timescale 1ns/10ps
module sepp_buf_mem (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data
);

	typedef struct packed {
		logic [sepp_pkg::BUF_DEPTH-1:0][7:0] cells;
		logic [7:0] rd_data;
	} sepp_mem_s;

	sepp_mem_s s;
	sepp_mem_s next_s;

	always_comb begin
		next_s = s;
		next_s.rd_data = s.cells[rd_addr];
		if (wr_en) begin
			next_s.cells[wr_addr] = wr_data;
		end
		if (rst) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	assign rd_data = s.rd_data;

endmodule

// file: rtl/sepp_port.sv
// I2C client packet layer: function decode, command and result buffers,
// sleep, idle, wake detection and watchdog.
// Assumes a command engine on ref_clk and an open-drain SDA pad outside.
`timescale 1ns/10ps
// Overview of operation
// - The byte after the device address in a write selects the function.
// - Code 0x00 clears the buffer pointers so transfers restart at zero.
// - Code 0x01 sleeps, clears volatile state, ignores the bus until wake.
// - Code 0x02 idles, ignores the bus until wake, keeps retained state.
// - Code 0x03 appends following bytes to the input command buffer.
// - Resync reads may return buffer data; undriven bytes read as 0xFF.
// - Sleep resets engine and buffers; sleep or idle taken awake, not busy.
// - Watchdog expiry while awake forces sleep and loses volatile state.
// - Wake from idle restarts the watchdog and keeps retained state.
// - Reads return the output group; default group is count four.
// - Respond only when address bits 7..1 match the configured address.
// - Each read byte is the next output byte; results rereadable.
// - Read address is not acked while busy, idle or asleep.
// - Read address is not acked while a partial command is held.
// - First byte is the count; extra bytes ignored; Stop starts execution.
// - Watchdog forces sleep about 1.3 s after wake when config bit 2 is 0.
module sepp_port #(
	parameter int WAKE_LOW_CYCLES = sepp_pkg::WAKE_LOW_CYCLES,
	parameter int WATCHDOG_CYCLES = sepp_pkg::WATCHDOG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [6:0] dev_addr,
	input wire logic [7:0] chip_option_config,
	output logic busy,
	output logic cmd_start,
	output logic asleep,
	output logic idle_mode,
	output logic volatile_clear,
	input wire logic [6:0] cmd_rd_addr,
	output logic [7:0] cmd_rd_data,
	input wire logic rsp_wr_en,
	input wire logic [6:0] rsp_wr_addr,
	input wire logic [7:0] rsp_wr_data,
	input wire logic exec_done
);

	typedef struct packed {
		logic [2:0] req_sync;
		logic [1:0] sda_sync;
		logic ack_tgl;
		logic [7:0] rd_byte;
		logic rd_wait;
		logic [1:0] rd_didx;
		sepp_pkg::sepp_mode_e mode;
		logic busy;
		logic cmd_start;
		logic vol_clear;
		logic asleep;
		logic idle;
		logic listen;
		logic readable;
		logic [7:0] func;
		logic [7:0] in_ptr;
		logic [7:0] cmd_len;
		logic [6:0] out_ptr;
		logic rsp_valid;
		logic [sepp_pkg::WD_W-1:0] wd;
		logic [sepp_pkg::WL_W-1:0] wl;
	} sepp_ref_s;

	typedef struct packed {
		logic [1:0] rst_m;
		logic [1:0] scl_m;
		logic [1:0] sda_m;
		logic scl_p;
		logic sda_p;
		logic [1:0] lis_m;
		logic [1:0] rdy_m;
		logic [1:0] ack_m;
		sepp_pkg::sepp_lstate_e state;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic rw;
		logic ackgo;
		logic first;
		logic wr_pkt;
		logic oe;
		logic sda_o;
		logic req_tgl;
		sepp_pkg::sepp_ev_e ev_kind;
		logic [7:0] ev_data;
	} sepp_link_s;

	sepp_ref_s r;
	sepp_ref_s next_r;
	sepp_link_s l;
	sepp_link_s next_l;

	logic cmd_we;
	logic [6:0] cmd_wa;
	logic [7:0] cmd_wd;
	logic [7:0] out_rd_data;

	sepp_buf_mem u_cmd_buf (
		.clk(ref_clk),
		.rst(rst),
		.wr_en(cmd_we),
		.wr_addr(cmd_wa),
		.wr_data(cmd_wd),
		.rd_addr(cmd_rd_addr),
		.rd_data(cmd_rd_data)
	);

	sepp_buf_mem u_out_buf (
		.clk(ref_clk),
		.rst(rst),
		.wr_en(rsp_wr_en),
		.wr_addr(rsp_wr_addr),
		.wr_data(rsp_wr_data),
		.rd_addr(r.out_ptr),
		.rd_data(out_rd_data)
	);

	// Reference domain: packet decode, buffers, power modes
	always_comb begin
		logic ev;
		logic go_sleep;
		logic [7:0] dflt;
		ev = 1'b0;
		go_sleep = 1'b0;
		dflt = sepp_pkg::GROUP_COUNT;
		next_r = r;
		cmd_we = 1'b0;
		cmd_wa = r.in_ptr[6:0];
		cmd_wd = l.ev_data;
		next_r.req_sync = {r.req_sync[1:0], l.req_tgl};
		next_r.sda_sync = {r.sda_sync[0], sda_in};
		next_r.cmd_start = 1'b0;
		next_r.vol_clear = 1'b0;
		ev = r.req_sync[2] ^ r.req_sync[1];

		case (r.rd_didx)
			2'h0: dflt = sepp_pkg::GROUP_COUNT;
			2'h1: dflt = sepp_pkg::GROUP_STATUS;
			2'h2: dflt = sepp_pkg::GROUP_CRC_LO;
			default: dflt = sepp_pkg::GROUP_CRC_HI;
		endcase

		// Read data is one cycle behind the pointer; answer then
		if (r.rd_wait) begin
			next_r.rd_byte = r.rsp_valid ? out_rd_data : dflt;
			next_r.ack_tgl = ~r.ack_tgl;
			next_r.rd_wait = 1'b0;
		end

		if (ev) begin
			if (l.ev_kind != sepp_pkg::SEPP_EV_RD) begin
				next_r.ack_tgl = ~r.ack_tgl;
			end
			if (r.mode == sepp_pkg::SEPP_M_AWAKE) begin
				case (l.ev_kind)
					sepp_pkg::SEPP_EV_WADDR: begin
						next_r.func = l.ev_data;
						if (l.ev_data == sepp_pkg::FUNC_RESET) begin
							next_r.in_ptr = sepp_pkg::RESET_BYTE;
							next_r.cmd_len = sepp_pkg::RESET_BYTE;
							next_r.out_ptr = sepp_pkg::RESET_PTR;
						end
					end
					sepp_pkg::SEPP_EV_WDATA: begin
						if (r.func == sepp_pkg::FUNC_CMD && !r.busy &&
							r.in_ptr < sepp_pkg::BUF_DEPTH_B &&
							(r.in_ptr == 8'h00 || r.in_ptr < r.cmd_len)) begin
							cmd_we = 1'b1;
							next_r.in_ptr = r.in_ptr + 8'h01;
							if (r.in_ptr == 8'h00) begin
								next_r.cmd_len = l.ev_data;
							end
						end
					end
					sepp_pkg::SEPP_EV_STOP: begin
						next_r.func = sepp_pkg::FUNC_NONE;
						case (r.func)
							sepp_pkg::FUNC_SLEEP: begin
								go_sleep = !r.busy;
							end
							sepp_pkg::FUNC_IDLE: begin
								if (!r.busy) begin
									next_r.mode = sepp_pkg::SEPP_M_IDLE;
								end
							end
							sepp_pkg::FUNC_CMD: begin
								if (!r.busy && r.cmd_len != 8'h00 &&
									r.in_ptr >= r.cmd_len) begin
									next_r.busy = 1'b1;
									next_r.cmd_start = 1'b1;
									next_r.rsp_valid = 1'b0;
									next_r.out_ptr = sepp_pkg::RESET_PTR;
								end
							end
							default: begin
								next_r.func = sepp_pkg::FUNC_NONE;
							end
						endcase
					end
					default: begin
						// Fetch the byte at the pointer; 7-bit pointer wraps
						next_r.rd_wait = 1'b1;
						next_r.rd_didx = r.out_ptr[1:0];
						next_r.out_ptr = r.out_ptr + 7'h01;
					end
				endcase
			end else if (l.ev_kind == sepp_pkg::SEPP_EV_RD) begin
				next_r.rd_wait = 1'b1;
				next_r.rd_didx = r.out_ptr[1:0];
			end
		end

		if (exec_done && r.busy) begin
			next_r.busy = 1'b0;
			next_r.rsp_valid = 1'b1;
			next_r.out_ptr = sepp_pkg::RESET_PTR;
			next_r.in_ptr = sepp_pkg::RESET_BYTE;
			next_r.cmd_len = sepp_pkg::RESET_BYTE;
		end

		// Watchdog runs only while awake and not disabled by config
		if (r.mode == sepp_pkg::SEPP_M_AWAKE &&
			!chip_option_config[sepp_pkg::WATCHDOG_BIT]) begin
			next_r.wd = r.wd + 1'b1;
			if (r.wd >= sepp_pkg::WD_W'(WATCHDOG_CYCLES - 1)) begin
				go_sleep = 1'b1;
			end
		end else begin
			next_r.wd = '0;
		end

		// Wake: SDA held low long enough, acted on at its rise
		if (r.mode != sepp_pkg::SEPP_M_AWAKE) begin
			if (!r.sda_sync[1]) begin
				if (r.wl != '1) begin
					next_r.wl = r.wl + 1'b1;
				end
			end else begin
				next_r.wl = '0;
				if (r.wl >= sepp_pkg::WL_W'(WAKE_LOW_CYCLES)) begin
					next_r.mode = sepp_pkg::SEPP_M_AWAKE;
					next_r.wd = '0;
				end
			end
		end else begin
			next_r.wl = '0;
		end

		if (go_sleep) begin
			next_r.mode = sepp_pkg::SEPP_M_SLEEP;
			next_r.busy = 1'b0;
			next_r.in_ptr = sepp_pkg::RESET_BYTE;
			next_r.cmd_len = sepp_pkg::RESET_BYTE;
			next_r.out_ptr = sepp_pkg::RESET_PTR;
			next_r.rsp_valid = 1'b0;
			next_r.func = sepp_pkg::FUNC_NONE;
			next_r.vol_clear = 1'b1;
			next_r.wd = '0;
		end

		if (rst) begin
			next_r.ack_tgl = 1'b0;
			next_r.rd_byte = sepp_pkg::RESET_BYTE;
			next_r.rd_wait = 1'b0;
			next_r.rd_didx = 2'h0;
			next_r.mode = sepp_pkg::SEPP_M_SLEEP;
			next_r.busy = 1'b0;
			next_r.cmd_start = 1'b0;
			next_r.vol_clear = 1'b0;
			next_r.func = sepp_pkg::FUNC_NONE;
			next_r.in_ptr = sepp_pkg::RESET_BYTE;
			next_r.cmd_len = sepp_pkg::RESET_BYTE;
			next_r.out_ptr = sepp_pkg::RESET_PTR;
			next_r.rsp_valid = 1'b0;
			next_r.wd = '0;
			next_r.wl = '0;
		end

		next_r.asleep = next_r.mode == sepp_pkg::SEPP_M_SLEEP;
		next_r.idle = next_r.mode == sepp_pkg::SEPP_M_IDLE;
		next_r.listen = next_r.mode == sepp_pkg::SEPP_M_AWAKE;
		next_r.readable = next_r.listen && !next_r.busy &&
			next_r.in_ptr == 8'h00;
	end

	always_ff @(posedge ref_clk) begin
		r <= next_r;
	end

	// Link domain: bit level engine sampling SCL and SDA
	always_comb begin
		logic scl_s;
		logic sda_s;
		logic rise;
		logic fall;
		logic start_c;
		logic stop_c;
		logic hs_busy;
		logic ev_go;
		sepp_pkg::sepp_ev_e ev_k;
		logic [7:0] ev_d;
		logic [7:0] nbyte;
		next_l = l;
		next_l.rst_m = {l.rst_m[0], rst};
		next_l.scl_m = {l.scl_m[0], scl_in};
		next_l.sda_m = {l.sda_m[0], sda_in};
		next_l.scl_p = l.scl_m[1];
		next_l.sda_p = l.sda_m[1];
		next_l.lis_m = {l.lis_m[0], r.listen};
		next_l.rdy_m = {l.rdy_m[0], r.readable};
		next_l.ack_m = {l.ack_m[0], r.ack_tgl};
		scl_s = l.scl_m[1];
		sda_s = l.sda_m[1];
		rise = scl_s && !l.scl_p;
		fall = !scl_s && l.scl_p;
		start_c = scl_s && l.scl_p && l.sda_p && !sda_s;
		stop_c = scl_s && l.scl_p && !l.sda_p && sda_s;
		hs_busy = l.req_tgl != l.ack_m[1];
		ev_go = 1'b0;
		ev_k = sepp_pkg::SEPP_EV_STOP;
		ev_d = sepp_pkg::RESET_BYTE;
		nbyte = {l.shreg[6:0], sda_s};

		if (start_c) begin
			// A Start aborts any byte in flight
			next_l.oe = 1'b0;
			next_l.cnt = 4'h0;
			next_l.first = 1'b1;
			next_l.state = l.lis_m[1] ? sepp_pkg::SEPP_L_ADDR :
				sepp_pkg::SEPP_L_IDLE;
		end else if (stop_c) begin
			next_l.oe = 1'b0;
			next_l.state = sepp_pkg::SEPP_L_IDLE;
			next_l.wr_pkt = 1'b0;
			ev_go = l.wr_pkt;
		end else begin
			case (l.state)
				sepp_pkg::SEPP_L_ADDR, sepp_pkg::SEPP_L_WR: begin
					if (rise) begin
						next_l.shreg = nbyte;
						next_l.cnt = l.cnt + 4'h1;
						if (l.cnt == sepp_pkg::LAST_BIT) begin
							next_l.cnt = 4'h0;
							next_l.ackgo = 1'b0;
							next_l.state = sepp_pkg::SEPP_L_ACK;
							if (l.state == sepp_pkg::SEPP_L_WR) begin
								ev_go = 1'b1;
								ev_k = l.first ? sepp_pkg::SEPP_EV_WADDR :
									sepp_pkg::SEPP_EV_WDATA;
								ev_d = nbyte;
								next_l.first = 1'b0;
							end else if (nbyte[7:1] == dev_addr &&
								(nbyte[0] ? l.rdy_m[1] : l.lis_m[1])) begin
								next_l.rw = nbyte[0];
								if (nbyte[0]) begin
									ev_go = 1'b1;
									ev_k = sepp_pkg::SEPP_EV_RD;
								end else begin
									next_l.wr_pkt = 1'b1;
								end
							end else begin
								next_l.state = sepp_pkg::SEPP_L_IDLE;
							end
						end
					end
				end
				sepp_pkg::SEPP_L_ACK: begin
					if (fall) begin
						if (!l.ackgo) begin
							next_l.oe = 1'b1;
							next_l.ackgo = 1'b1;
						end else if (l.rw) begin
							next_l.tx = r.rd_byte;
							next_l.oe = ~r.rd_byte[7];
							next_l.cnt = 4'h0;
							next_l.state = sepp_pkg::SEPP_L_RD;
						end else begin
							next_l.oe = 1'b0;
							next_l.cnt = 4'h0;
							next_l.state = sepp_pkg::SEPP_L_WR;
						end
					end
				end
				sepp_pkg::SEPP_L_RD: begin
					if (fall) begin
						if (l.cnt == sepp_pkg::LAST_BIT) begin
							next_l.oe = 1'b0;
							next_l.state = sepp_pkg::SEPP_L_MACK;
						end else begin
							next_l.cnt = l.cnt + 4'h1;
							next_l.tx = {l.tx[6:0], 1'b0};
							next_l.oe = ~l.tx[6];
						end
					end
				end
				sepp_pkg::SEPP_L_MACK: begin
					if (rise) begin
						if (!sda_s) begin
							ev_go = 1'b1;
							ev_k = sepp_pkg::SEPP_EV_RD;
							next_l.ackgo = 1'b1;
							next_l.state = sepp_pkg::SEPP_L_ACK;
						end else begin
							next_l.state = sepp_pkg::SEPP_L_IDLE;
						end
					end
				end
				default: begin
					next_l.oe = 1'b0;
				end
			endcase
		end

		// Sleep or idle reached mid-transfer: drop off the bus at once
		if (!l.lis_m[1]) begin
			next_l.state = sepp_pkg::SEPP_L_IDLE;
			next_l.oe = 1'b0;
			next_l.wr_pkt = 1'b0;
		end

		if (ev_go && !hs_busy) begin
			next_l.req_tgl = ~l.req_tgl;
			next_l.ev_kind = ev_k;
			next_l.ev_data = ev_d;
		end

		if (l.rst_m[1]) begin
			next_l.state = sepp_pkg::SEPP_L_IDLE;
			next_l.cnt = 4'h0;
			next_l.shreg = sepp_pkg::RESET_BYTE;
			next_l.tx = sepp_pkg::RESET_BYTE;
			next_l.rw = 1'b0;
			next_l.ackgo = 1'b0;
			next_l.first = 1'b0;
			next_l.wr_pkt = 1'b0;
			next_l.oe = 1'b0;
			next_l.req_tgl = 1'b0;
			next_l.ev_kind = sepp_pkg::SEPP_EV_STOP;
			next_l.ev_data = sepp_pkg::RESET_BYTE;
		end
		next_l.sda_o = 1'b0;
	end

	always_ff @(posedge link_clk) begin
		l <= next_l;
	end

	assign sda_out = l.sda_o;
	assign sda_oe = l.oe;
	assign busy = r.busy;
	assign cmd_start = r.cmd_start;
	assign asleep = r.asleep;
	assign idle_mode = r.idle;
	assign volatile_clear = r.vol_clear;

endmodule

// file: bench/sepp_port_sva.sv
// Checker for the packet port: start, busy, sleep and watchdog relations.
// Assumes it is bound to sepp_port and sees only that module's ports.
`timescale 1ns/10ps
module sepp_port_sva #(
	parameter int WATCHDOG_CYCLES = 2000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sda_oe,
	input wire logic [7:0] chip_option_config,
	input wire logic busy,
	input wire logic cmd_start,
	input wire logic asleep,
	input wire logic idle_mode,
	input wire logic volatile_clear,
	input wire logic exec_done
);
	logic [31:0] wd_cnt;
	// Cycles spent awake with the watchdog enabled
	always_ff @(posedge ref_clk) begin
		if (rst || asleep || idle_mode || chip_option_config[2])
			wd_cnt <= 32'h0000_0000;
		else
			wd_cnt <= wd_cnt + 32'h0000_0001;
	end
	start_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_start |=> !cmd_start) else $error("start held");
	start_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_start |-> ##[0:1] busy) else $error("no busy");
	start_free_a: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_start |-> !$past(busy) && !asleep && !idle_mode)
		else $error("start not free");
	done_ends_a: assert property (@(posedge ref_clk) disable iff (rst)
		busy && exec_done |=> !busy) else $error("busy stuck");
	clear_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		volatile_clear |=> !volatile_clear) else $error("clear held");
	clear_sleep_a: assert property (@(posedge ref_clk) disable iff (rst)
		volatile_clear |-> ##[0:1] asleep) else $error("clear no sleep");
	sleep_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(asleep) |-> ##[0:1] !busy) else $error("busy asleep");
	quiet_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
		(asleep || idle_mode) [*3] |-> !sda_oe) else $error("drives");
	wd_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
		wd_cnt < WATCHDOG_CYCLES + 8) else $error("no watchdog");
endmodule

bind sepp_port sepp_port_sva #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) chk (
	.ref_clk(ref_clk), .rst(rst), .sda_oe(sda_oe),
	.chip_option_config(chip_option_config), .busy(busy),
	.cmd_start(cmd_start), .asleep(asleep), .idle_mode(idle_mode),
	.volatile_clear(volatile_clear), .exec_done(exec_done));

// file: bench/sepp_host_model.sv
// Host controller model: drives SCL and SDA and resolves the SDA wire.
// Assumes the bench calls its tasks; the device pulls SDA only via oe.
`timescale 1ns/10ps
module sepp_host_model #(
	parameter int QTR = 25,
	parameter int WAKE_LOW = 500
) (
	input wire logic ref_clk,
	input wire logic sda_oe,
	input wire logic sda_out,
	output logic scl,
	output logic sda
);
	logic pull_low;
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// Pull-up wins when nobody pulls low
	assign sda = !pull_low && !(sda_oe && !sda_out);
	task automatic q();
		repeat (QTR) @(posedge ref_clk);
	endtask
	task automatic start();
		pull_low <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		pull_low <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic stop();
		pull_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		pull_low <= 1'b0;
		q();
	endtask
	task automatic bit_x(input logic b, output logic s);
		pull_low <= !b;
		q();
		scl <= 1'b1;
		q();
		s = sda;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(last, s);
	endtask
	// Wake pulse, then a shortened wake-high delay
	task automatic wake();
		pull_low <= 1'b1;
		repeat (WAKE_LOW) @(posedge ref_clk);
		pull_low <= 1'b0;
		repeat (40) @(posedge ref_clk);
	endtask
	task automatic resync();
		logic s;
		start();
		repeat (9) bit_x(1'b1, s);
		start();
		stop();
	endtask
endmodule

// file: bench/sepp_port_tb_top.sv
// Bench for the packet port: host model on the link, engine stub here.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module sepp_port_tb_top;
	localparam logic [6:0] DEV = 7'h5A;
	localparam int WD = 3000;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] cfg = 8'h04;
	logic [6:0] cmd_rd_addr = 7'h00;
	logic rsp_wr_en = 1'b0;
	logic [6:0] rsp_wr_addr = 7'h00;
	logic [7:0] rsp_wr_data = 8'h00;
	logic exec_done = 1'b0;
	logic scl, sda, sda_out, sda_oe, busy, cmd_start, asleep, idle_mode, vclr;
	logic [7:0] cmd_rd_data;
	int err_total = 0;
	int cmp_count = 0;
	int starts = 0;
	int clears = 0;
	always #5 ref_clk = ~ref_clk;
	initial #1.7 forever #3 link_clk = ~link_clk;
	sepp_host_model #(.QTR(25), .WAKE_LOW(500)) host (.ref_clk(ref_clk),
		.sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
	sepp_port #(.WAKE_LOW_CYCLES(400), .WATCHDOG_CYCLES(WD)) uut (
		.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr(DEV),
		.chip_option_config(cfg), .busy(busy), .cmd_start(cmd_start),
		.asleep(asleep), .idle_mode(idle_mode), .volatile_clear(vclr),
		.cmd_rd_addr(cmd_rd_addr), .cmd_rd_data(cmd_rd_data),
		.rsp_wr_en(rsp_wr_en), .rsp_wr_addr(rsp_wr_addr),
		.rsp_wr_data(rsp_wr_data), .exec_done(exec_done));
	always @(posedge ref_clk) begin
		if (cmd_start === 1'b1)
			starts <= starts + 1;
		if (vclr === 1'b1)
			clears <= clears + 1;
	end
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd_grp(input logic ack, input int n, input logic [39:0] e);
		logic a;
		logic [7:0] d;
		host.start();
		host.wr_byte({DEV, 1'b1}, a);
		chk("read ack", a, ack);
		for (int i = 0; i < n && a; i++) begin
			host.rd_byte(i == n - 1, d);
			chk("read byte", d, e[39 - 8 * i -: 8]);
		end
		host.stop();
	endtask
	task automatic wr_pkt(input int n, input logic [31:0] b);
		logic a;
		host.start();
		host.wr_byte({DEV, 1'b0}, a);
		chk("write ack", a, 1'b1);
		for (int i = 0; i < n; i++) begin
			host.wr_byte(b[31 - 8 * i -: 8], a);
			chk("data ack", a, 1'b1);
		end
		host.stop();
		repeat (20) @(posedge ref_clk);
	endtask
	task automatic t_wake();
		logic a;
		chk("asleep", asleep, 1'b1);
		rd_grp(1'b0, 0, 40'h0);
		host.wake();
		chk("awake", asleep, 1'b0);
		rd_grp(1'b1, 5, 40'h04_0000_0004);
		host.start();
		host.wr_byte({DEV ^ 7'h01, 1'b1}, a);
		chk("other addr", a, 1'b0);
		host.stop();
		rd_grp(1'b1, 1, 40'h00_0000_0000);
		wr_pkt(1, 32'h0000_0000);
		rd_grp(1'b1, 2, 40'h04_0000_0000);
	endtask
	task automatic t_cmd();
		logic [39:0] ce;
		ce = 40'h04_1155_6600;
		wr_pkt(3, 32'h0304_1100);
		chk("early start", starts[7:0], 8'h00);
		rd_grp(1'b0, 0, 40'h0);
		wr_pkt(4, 32'h0355_6677);
		chk("starts", starts[7:0], 8'h01);
		chk("busy", busy, 1'b1);
		rd_grp(1'b0, 0, 40'h0);
		wr_pkt(1, 32'h0100_0000);
		chk("busy sleep", asleep, 1'b0);
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk);
			cmd_rd_addr <= i[6:0];
			@(posedge ref_clk);
			#1;
			chk("cmd byte", cmd_rd_data, ce[39 - 8 * i -: 8]);
		end
		@(posedge ref_clk);
		for (int i = 0; i < 3; i++) begin
			rsp_wr_en <= 1'b1;
			rsp_wr_addr <= i[6:0];
			rsp_wr_data <= ce[31 - 8 * i -: 8] ^ 8'hF6;
			@(posedge ref_clk);
		end
		rsp_wr_en <= 1'b0;
		exec_done <= 1'b1;
		@(posedge ref_clk);
		exec_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("done", busy, 1'b0);
		rd_grp(1'b1, 3, 40'hE7_A390_0000);
		wr_pkt(1, 32'h0000_0000);
		rd_grp(1'b1, 1, 40'hE7_0000_0000);
	endtask
	task automatic t_idle();
		wr_pkt(1, 32'h0200_0000);
		chk("idle", idle_mode, 1'b1);
		rd_grp(1'b0, 0, 40'h0);
		host.wake();
		chk("idle end", idle_mode, 1'b0);
		chk("kept", clears[7:0], 8'h00);
		wr_pkt(1, 32'h0000_0000);
		rd_grp(1'b1, 3, 40'hE7_A390_0000);
	endtask
	task automatic t_sleep();
		wr_pkt(1, 32'h0100_0000);
		chk("sleep", asleep, 1'b1);
		chk("clear", clears[7:0], 8'h01);
		rd_grp(1'b0, 0, 40'h0);
		host.wake();
		host.resync();
		rd_grp(1'b1, 1, 40'h04_0000_0000);
		wr_pkt(1, 32'h0000_0000);
	endtask
	task automatic t_wd();
		wr_pkt(1, 32'h0100_0000);
		cfg <= 8'h00;
		host.wake();
		repeat (WD - 300) @(posedge ref_clk);
		chk("wd early", asleep, 1'b0);
		repeat (600) @(posedge ref_clk);
		chk("wd sleep", asleep, 1'b1);
		chk("wd clear", clears[7:0], 8'h03);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		t_wake();
		t_cmd();
		t_idle();
		t_sleep();
		t_wd();
		conclude();
	end
	initial begin
		repeat (90000) @(posedge ref_clk);
		err_total++;
		conclude();
	end
endmodule
